// [bench/testbench.sv]
// self-checking bench for the interrupt arming block
`timescale 1ns/1ns
`include "vpie_consts.svh"
module testbench;
   logic        clk = 1'h0, rst_n = 1'h0, hsel = 1'h0, hwrite = 1'h0, rdp = 1'h0;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, s = 32'hD20C, en;
   logic        hreadyout, hresp, stream_error, line_done, video_error_irq, irq;
   logic [3:0]  frame_done, frame_irq;
   logic [5:0]  req = 6'h0;
   logic [31:0] q[$];
   logic [11:0] ofs[6] = '{`VPIE_OFS_ENABLE, `VPIE_OFS_SET, `VPIE_OFS_CTRL0, `VPIE_OFS_STAT,
                           `VPIE_OFS_STATEN, 12'h040};
   int          n_mismatch = 0, cmp_count = 0;
   always #25 clk = ~clk;
   vpie_top i_vpie_top(.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .stream_error, .frame_done, .line_done,
      .video_error_irq, .frame_irq, .irq);
   vpie_src i_vpie_src(.clk, .req, .stream_error, .frame_done, .line_done);
   function automatic logic [31:0] xs();
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic wrdy();
      int k;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (hreadyout !== 1'h1 && k < 50);
      if (hreadyout !== 1'h1) begin
         n_mismatch++;
         wrap_up();
      end
   endtask
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      hsel   <= 1'h1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr  <= {20'h0, a};
      wrdy();
      htrans <= 2'h0;
      hwdata <= d;
      rdp    <= !w;
      wrdy();
      rdp    <= 1'h0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      q.push_back(e);
      xfer(1'h0, a, xs());
   endtask
   task automatic ev(input logic [5:0] m, input logic [4:0] e);
      req <= m;
      @(posedge clk);
      req <= 6'h0;
      @(posedge clk);
      #1 chk({video_error_irq, frame_irq}, e);
      @(posedge clk);
      #1 chk({video_error_irq, frame_irq}, 5'h0);
      @(posedge clk);
   endtask
   // read data is judged in its data phase against the oldest note
   always @(posedge clk) begin
      if (rdp && hreadyout === 1'h1) begin
         chk(hrdata, q.pop_front());
      end
   end
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
      foreach (ofs[i]) rd(ofs[i], 32'h0);
      xfer(1'h1, `VPIE_OFS_SET, 32'h1F);
      rd(`VPIE_OFS_SET, 32'h0);
      en = xs() & 32'h1F;
      xfer(1'h1, `VPIE_OFS_ENABLE, en);
      xfer(1'h1, `VPIE_OFS_SET, 32'hFFFFFFFF);
      rd(`VPIE_OFS_SET, en);
      xfer(1'h1, `VPIE_OFS_ENABLE, 32'h1F);
      xfer(1'h1, `VPIE_OFS_SET, 32'h1F);
      rd(`VPIE_OFS_SET, 32'h1F);
      xfer(1'h1, `VPIE_OFS_SET, xs() & 32'hFFFFFFE0);
      rd(`VPIE_OFS_SET, 32'h1F);
      xfer(1'h1, `VPIE_OFS_CLEAR, 32'h5);
      rd(`VPIE_OFS_SET, 32'h1A);
      xfer(1'h1, `VPIE_OFS_STATEN, 32'h1F);
      ev(6'h10, 5'h08);
      ev(6'h08, 5'h00);
      ev(6'h02, 5'h00);
      ev(6'h20, 5'h10);
      #1 chk(irq, 32'h1);
      rd(`VPIE_OFS_STAT, 32'h18);
      xfer(1'h1, `VPIE_OFS_STATCLR, 32'h1F);
      rd(`VPIE_OFS_STAT, 32'h0);
      #1 chk(irq, 32'h0);
      xfer(1'h1, `VPIE_OFS_CTRL0, 32'h3);
      ev(6'h01, 5'h02);
      ev(6'h04, 5'h00);
      xfer(1'h1, `VPIE_OFS_CTRL0, 32'h0);
      ev(6'h04, 5'h02);
      xfer(1'h1, `VPIE_OFS_CLEAR, 32'h10);
      ev(6'h20, 5'h00);
      wrap_up();
   end
endmodule

// [bench/vpie_assertions.sv]
// assertion checker for the interrupt arming block
`timescale 1ns/1ns
module vpie_chk (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        hsel,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        stream_error,
   input wire logic [3:0]  frame_done,
   input wire logic        video_error_irq,
   input wire logic [3:0]  frame_irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_lone(b);
      b ##1 !b;
   endsequence
   a_zero_wait: assert property (hreadyout) else $error("wait state");
   a_resp_okay: assert property (!hresp) else $error("error response");
   a_upper_zero: assert property (hrdata[31:5] == 27'h0) else $error("reserved bits set");
   a_rdata_hold: assert property (!(hsel && htrans[1] && !hwrite) |=> $stable(hrdata))
      else $error("read data moved");
   a_err_cause: assert property (video_error_irq |-> $past(stream_error)) else $error("stray error");
   a_ch3_cause: assert property (frame_irq[3] |-> $past(frame_done[3])) else $error("stray ch3");
   a_ch2_cause: assert property (frame_irq[2] |-> $past(frame_done[2])) else $error("stray ch2");
   a_one_pulse: assert property (s_lone(frame_done[3]) |=> !frame_irq[3]) else $error("long pulse");
endmodule
bind vpie_top vpie_chk i_vpie_chk(.clk, .rst_n, .hsel, .htrans, .hwrite, .hrdata, .hreadyout,
   .hresp, .stream_error, .frame_done, .video_error_irq, .frame_irq);

// [bench/vpie_src.sv]
// event source model for the capture and display channels
`timescale 1ns/1ns
module vpie_src (
   input  wire logic       clk,
   input  wire logic [5:0] req,
   output logic            stream_error,
   output logic [3:0]      frame_done,
   output logic            line_done
);
   always_ff @(posedge clk) begin
      {stream_error, frame_done, line_done} <= req;
   end
endmodule

// [rtl/vpie_consts.svh]
// constants for the video port interrupt arming block
`ifndef VPIE_CONSTS_SVH
`define VPIE_CONSTS_SVH

// ==========================================================
// register byte offsets
`define VPIE_OFS_ENABLE  12'h000
`define VPIE_OFS_SET     12'h004
`define VPIE_OFS_CLEAR   12'h008
`define VPIE_OFS_CTRL0   12'h00C
`define VPIE_OFS_STAT    12'h010
`define VPIE_OFS_STATCLR 12'h014
`define VPIE_OFS_STATEN  12'h018
`define VPIE_ADDR_W      12

// ==========================================================
// field layout
`define VPIE_NSRC        5
`define VPIE_BIT_ERR     4
`define VPIE_BIT_CH3     3
`define VPIE_BIT_CH2     2
`define VPIE_BIT_CH1     1
`define VPIE_BIT_CH0     0
`define VPIE_FMT_W       2
`define VPIE_FMT_RAW     2'h3
`define VPIE_PAD_W       27
`define VPIE_CPAD_W      30

// ==========================================================
// reset values and bus codes
`define VPIE_SRC_RST     5'h00
`define VPIE_FMT_RST     2'h0
`define VPIE_WORD_RST    32'h00000000
`define VPIE_TRANS_BIT   1
`define VPIE_RESP_OKAY   1'h0

`endif

// [rtl/vpie_pkg.sv]
// types shared by the video port interrupt arming block
package vpie_pkg;
   typedef logic [4:0]  vpie_src_t;
   typedef logic [31:0] vpie_word_t;
   typedef logic [11:0] vpie_addr_t;
   typedef logic [1:0]  vpie_fmt_t;
endpackage

// [rtl/vpie_top.sv]
// video port interrupt arming registers with ahb-lite slave
`timescale 1ns/1ns
`include "vpie_consts.svh"

module vpie_top (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             hsel,
   input  wire logic [31:0]      haddr,
   input  wire logic [1:0]       htrans,
   input  wire logic             hwrite,
   input  wire logic [2:0]       hsize,
   input  wire logic [31:0]      hwdata,
   input  wire logic             hready,
   output logic      [31:0]      hrdata,
   output logic                  hreadyout,
   output logic                  hresp,
   input  wire logic             stream_error,
   input  wire logic [3:0]       frame_done,
   input  wire logic             line_done,
   output logic                  video_error_irq,
   output logic      [3:0]       frame_irq,
   output logic                  irq
);

   // ==========================================================
   // state
   vpie_pkg::vpie_src_t  enable_r;
   vpie_pkg::vpie_src_t  armed_r;
   vpie_pkg::vpie_src_t  armed_nxt;
   vpie_pkg::vpie_src_t  stat_r;
   vpie_pkg::vpie_src_t  stat_nxt;
   vpie_pkg::vpie_src_t  stat_en_r;
   vpie_pkg::vpie_src_t  src_evt;
   vpie_pkg::vpie_src_t  gated_evt;
   vpie_pkg::vpie_fmt_t  fmt_r;
   vpie_pkg::vpie_addr_t dp_addr_r;
   vpie_pkg::vpie_word_t rdata_r;
   vpie_pkg::vpie_word_t rd_mux;
   logic                 dp_wr_r;
   logic                 addr_phase;
   logic                 wr_enable;
   logic                 wr_set;
   logic                 wr_clear;
   logic                 wr_ctrl;
   logic                 wr_statclr;
   logic                 wr_staten;
   logic                 ch1_line_mode;
   logic                 ch1_evt;
   logic                 error_irq_r;
   logic [3:0]           frame_irq_r;
   logic                 irq_r;

   // ==========================================================
   // helpers
   function automatic logic
      wr_hit(input vpie_pkg::vpie_addr_t a,
             input vpie_pkg::vpie_addr_t ofs,
             input logic                 wr);
      wr_hit = wr && (a == ofs);
   endfunction

   function automatic vpie_pkg::vpie_word_t
      pad_src(input vpie_pkg::vpie_src_t v);
      pad_src = {{`VPIE_PAD_W{1'b0}}, v};
   endfunction

   // ==========================================================
   // ahb-lite slave, zero wait, always okay
   assign hreadyout = 1'b1;
   assign hresp     = `VPIE_RESP_OKAY;
   assign hrdata    = rdata_r;

   assign addr_phase = hsel && hready
                       && htrans[`VPIE_TRANS_BIT];

   // data phase address and direction
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dp_addr_r <= `VPIE_OFS_ENABLE;
         dp_wr_r   <= 1'b0;
      end else if (hready) begin
         dp_wr_r <= addr_phase && hwrite;
         if (addr_phase) begin
            dp_addr_r <= haddr[`VPIE_ADDR_W-1:0];
         end
      end
   end

   assign wr_enable  = wr_hit(dp_addr_r,
                              `VPIE_OFS_ENABLE, dp_wr_r);
   assign wr_set     = wr_hit(dp_addr_r,
                              `VPIE_OFS_SET, dp_wr_r);
   assign wr_clear   = wr_hit(dp_addr_r,
                              `VPIE_OFS_CLEAR, dp_wr_r);
   assign wr_ctrl    = wr_hit(dp_addr_r,
                              `VPIE_OFS_CTRL0, dp_wr_r);
   assign wr_statclr = wr_hit(dp_addr_r,
                              `VPIE_OFS_STATCLR, dp_wr_r);
   assign wr_staten  = wr_hit(dp_addr_r,
                              `VPIE_OFS_STATEN, dp_wr_r);

   // read mux, write-only and unmapped read zero
   always_comb begin
      rd_mux = `VPIE_WORD_RST;
      case (haddr[`VPIE_ADDR_W-1:0])
         `VPIE_OFS_ENABLE: begin
            rd_mux = pad_src(enable_r);
         end
         `VPIE_OFS_SET: begin
            rd_mux = pad_src(armed_r);
         end
         `VPIE_OFS_CTRL0: begin
            rd_mux = {{`VPIE_CPAD_W{1'b0}}, fmt_r};
         end
         `VPIE_OFS_STAT: begin
            rd_mux = pad_src(stat_r);
         end
         `VPIE_OFS_STATEN: begin
            rd_mux = pad_src(stat_en_r);
         end
         default: begin
            rd_mux = `VPIE_WORD_RST;
         end
      endcase
   end

   // read data captured at the address phase
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= `VPIE_WORD_RST;
      end else if (addr_phase && !hwrite) begin
         rdata_r <= rd_mux;
      end
   end

   // ==========================================================
   // enable register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         enable_r <= `VPIE_SRC_RST;
      end else if (wr_enable) begin
         enable_r <= hwdata[`VPIE_NSRC-1:0];
      end
   end

   // ==========================================================
   // arming register, write one to set
   always_comb begin
      armed_nxt = armed_r;
      if (wr_set) begin
         // only ones set, gated by the enable bits
         armed_nxt = armed_r
                     | (hwdata[`VPIE_NSRC-1:0]
                        & enable_r);
      end
      if (wr_clear) begin
         armed_nxt = armed_r
                     & ~hwdata[`VPIE_NSRC-1:0];
      end
      // a dropped enable leaves its set bit reading zero
      armed_nxt = armed_nxt & enable_r;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         armed_r <= `VPIE_SRC_RST;
      end else begin
         armed_r <= armed_nxt;
      end
   end

   // ==========================================================
   // control 0 for channel 1, format field
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fmt_r <= `VPIE_FMT_RST;
      end else if (wr_ctrl) begin
         fmt_r <= hwdata[`VPIE_FMT_W-1:0];
      end
   end

   assign ch1_line_mode = (fmt_r == `VPIE_FMT_RAW);

   // channel 1 source: lines in raw mode, else frames
   assign ch1_evt = ch1_line_mode ? line_done
                                  : frame_done[`VPIE_BIT_CH1];

   // ==========================================================
   // source events gated by the armed bits
   always_comb begin
      src_evt = `VPIE_SRC_RST;
      src_evt[`VPIE_BIT_ERR] = stream_error;
      src_evt[`VPIE_BIT_CH3] = frame_done[`VPIE_BIT_CH3];
      src_evt[`VPIE_BIT_CH2] = frame_done[`VPIE_BIT_CH2];
      src_evt[`VPIE_BIT_CH1] = ch1_evt;
      src_evt[`VPIE_BIT_CH0] = frame_done[`VPIE_BIT_CH0];
   end

   assign gated_evt = src_evt & armed_r;

   // ==========================================================
   // per-source interrupt outputs
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         error_irq_r <= 1'b0;
      end else begin
         error_irq_r <= gated_evt[`VPIE_BIT_ERR];
      end
   end

   // one pulse per frame done pulse, per line done pulse on channel 1 in raw mode
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         frame_irq_r <= 4'h0;
      end else begin
         frame_irq_r <= gated_evt[`VPIE_BIT_CH3:`VPIE_BIT_CH0];
      end
   end

   assign video_error_irq = error_irq_r;
   assign frame_irq       = frame_irq_r;

   // ==========================================================
   // sticky status, set wins over clear
   always_comb begin
      stat_nxt = stat_r;
      if (wr_statclr) begin
         stat_nxt = stat_r & ~hwdata[`VPIE_NSRC-1:0];
      end
      stat_nxt = stat_nxt | gated_evt;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stat_r <= `VPIE_SRC_RST;
      end else begin
         stat_r <= stat_nxt;
      end
   end

   // status enable register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stat_en_r <= `VPIE_SRC_RST;
      end else if (wr_staten) begin
         stat_en_r <= hwdata[`VPIE_NSRC-1:0];
      end
   end

   // ==========================================================
   // combined level interrupt
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(stat_nxt & stat_en_r);
      end
   end

   assign irq = irq_r;

   // hsize is not checked: only word accesses are used
   logic unused_ok;
   assign unused_ok = ^{hsize, haddr[31:`VPIE_ADDR_W]};

endmodule
